/* ibc_core.sv */
// Byte-level bus master: registers, byte sequencer, bit phase engine.
// Assumes a single clock, open-drain pins resolved outside the module,
// and pin inputs arriving asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "ibc_consts.svh"

module ibc_core
   import ibc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_ce,
   // Register port
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Interrupt
   output logic            o_irq,
   // Bus pins
   input  wire logic       i_scl,
   output logic            o_scl,
   output logic            o_scl_oe_n,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe_n
);

   //----------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------
   logic [15:0] div_q;
   logic [7:0]  ctrl_q;
   logic [7:0]  txd_q;
   logic [7:0]  rxd_q;
   logic        sta_q, sto_q, rdc_q, wrc_q, ack_q;
   logic        slave_ack_seen_q, busy_q, al_q, tip_q, if_q;
   logic        done;
   logic        al_ev;
   logic        core_en;
   logic        wr_cmd;

   assign core_en = ctrl_q[`IBC_CTRL_EN];
   assign wr_cmd  = i_ce && i_wr && (i_addr == `IBC_OFS_CMD);

   // divider bytes, software holds EN low
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_q <= `IBC_DIV_RESET;
      end else if (i_ce && i_wr) begin
         if (i_addr == `IBC_OFS_DIV_LO) div_q[7:0] <= i_wdata;
         if (i_addr == `IBC_OFS_DIV_HI) div_q[15:8] <= i_wdata;
      end
   end

   // control reserved bits stored as zero
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q <= `IBC_CTRL_RESET;
         txd_q  <= 8'h00;
      end else if (i_ce && i_wr) begin
         if (i_addr == `IBC_OFS_CTRL) ctrl_q <= {i_wdata[7:6], 6'h00};
         if (i_addr == `IBC_OFS_DATA) txd_q <= i_wdata;
      end
   end

   // command latch, taken only while enabled
   // STA, STO, RD and WR bits clear when the command finishes or arbitration is lost
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {sta_q, sto_q, rdc_q, wrc_q, ack_q} <= 5'h00;
      end else if (i_ce) begin
         if (done || al_ev) begin
            {sta_q, sto_q, rdc_q, wrc_q} <= 4'h0;
         end
         if (wr_cmd && core_en) begin
            sta_q <= i_wdata[`IBC_CMD_STA];
            sto_q <= i_wdata[`IBC_CMD_STO];
            rdc_q <= i_wdata[`IBC_CMD_RD];
            wrc_q <= i_wdata[`IBC_CMD_WR];
            ack_q <= i_wdata[`IBC_CMD_ACK];
         end
      end
   end

   // sticky flag, set wins; clear; done sets
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         if_q <= 1'b0;
      end else if (i_ce) begin
         if (done || al_ev) if_q <= 1'b1;
         else if (wr_cmd && i_wdata[`IBC_CMD_INTERRUPT_CLEAR]) if_q <= 1'b0;
      end
   end

   assign o_irq = if_q && ctrl_q[`IBC_CTRL_IEN];

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 8'h00;
      end else if (i_ce && i_rd) begin
         unique case (i_addr)
            `IBC_OFS_DIV_LO: o_rdata <= div_q[7:0];
            `IBC_OFS_DIV_HI: o_rdata <= div_q[15:8];
            `IBC_OFS_CTRL:   o_rdata <= ctrl_q;
            `IBC_OFS_DATA:   o_rdata <= rxd_q;
            `IBC_OFS_CMD:    o_rdata <= {slave_ack_seen_q, busy_q, al_q,
                                         3'h0, tip_q, if_q};
            default:         o_rdata <= 8'h00;
         endcase
      end
   end

   //----------------------------------------------------------------
   // Pin synchronisers and bus condition detect
   //----------------------------------------------------------------
   logic [2:0] scl_s, sda_s;
   logic       scl_f, sda_f, scl_fp, sda_fp;
   logic       start_det, stop_det;

   // Three stages; level changes once stages two and three agree
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_s  <= 3'h7;
         sda_s  <= 3'h7;
         scl_f  <= 1'b1;
         sda_f  <= 1'b1;
         scl_fp <= 1'b1;
         sda_fp <= 1'b1;
      end else if (i_ce) begin
         scl_s  <= {scl_s[1:0], i_scl};
         sda_s  <= {sda_s[1:0], i_sda};
         if (scl_s[2] == scl_s[1]) scl_f <= scl_s[2];
         if (sda_s[2] == sda_s[1]) sda_f <= sda_s[2];
         scl_fp <= scl_f;
         sda_fp <= sda_f;
      end
   end

   assign start_det = scl_f && scl_fp && sda_fp && !sda_f;
   assign stop_det  = scl_f && scl_fp && !sda_fp && sda_f;

   // bus busy from start and stop conditions
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_q <= 1'b0;
      end else if (i_ce) begin
         if (start_det) busy_q <= 1'b1;
         else if (stop_det) busy_q <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // Phase enable and bit engine
   //----------------------------------------------------------------
   logic [15:0] pcnt_q;
   logic        pen;
   ibc_bop_t    bop_q;
   logic [2:0]  ph_q;
   logic        scl_drv_q, sda_drv_q;
   logic        bit_done;
   logic        stretch;
   logic        stop_req_q;

   // high phase waits while SCL held low elsewhere
   assign stretch = scl_drv_q && !scl_f;

   logic        run_en;

   // work already taken runs on while disabled
   assign run_en = core_en || tip_q;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pcnt_q <= 16'h0000;
      end else if (i_ce) begin
         if (!run_en || pcnt_q == 16'h0000 || stretch) begin
            pcnt_q <= div_q;
         end else begin
            pcnt_q <= pcnt_q - 16'h0001;
         end
      end
   end

   assign pen = run_en && (pcnt_q == 16'h0000) && !stretch;

   // Last timed phase: stop ends after C, others after D
   function automatic logic last_phase(input ibc_bop_t op,
                                       input logic [2:0] ph);
      last_phase = (op == IBC_BOP_STOP) ? (ph == 3'h3) : (ph == 3'h4);
   endfunction : last_phase

   assign bit_done = pen && (bop_q != IBC_BOP_IDLE) &&
                     last_phase(bop_q, ph_q);

   ibc_bop_t   bop_d;
   logic       bit_tx;
   logic       rx_bit_q;

   // phase counter: idle, then A to D
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ph_q  <= 3'h0;
         bop_q <= IBC_BOP_IDLE;
      end else if (i_ce) begin
         if (al_ev) begin
            ph_q  <= 3'h0;
            bop_q <= IBC_BOP_IDLE;
         end else if (bop_q == IBC_BOP_IDLE) begin
            bop_q <= bop_d;
            ph_q  <= 3'h0;
         end else if (pen) begin
            if (last_phase(bop_q, ph_q)) begin
               bop_q <= IBC_BOP_IDLE;
               ph_q  <= 3'h0;
            end else begin
               ph_q <= ph_q + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_drv_q <= 1'b1;
         sda_drv_q <= 1'b1;
         rx_bit_q  <= 1'b1;
      end else if (i_ce && pen && bop_q != IBC_BOP_IDLE) begin
         unique case (bop_q)
            IBC_BOP_START: unique case (ph_q)
               3'h0: begin sda_drv_q <= 1'b1; end
               3'h1: begin scl_drv_q <= 1'b1; end
               3'h2: begin sda_drv_q <= 1'b0; end
               3'h3: begin scl_drv_q <= 1'b1; end
               default: begin scl_drv_q <= 1'b0; end
            endcase
            IBC_BOP_STOP: unique case (ph_q)
               3'h0: begin scl_drv_q <= 1'b0; sda_drv_q <= 1'b0; end
               3'h1: begin scl_drv_q <= 1'b1; end
               3'h2: begin scl_drv_q <= 1'b1; end
               default: begin sda_drv_q <= 1'b1; end
            endcase
            default: unique case (ph_q)
               3'h0: begin
                  scl_drv_q <= 1'b0;
                  sda_drv_q <= bit_tx;
               end
               3'h1: begin scl_drv_q <= 1'b1; end
               3'h2: begin rx_bit_q <= sda_f; end
               3'h3: begin scl_drv_q <= 1'b1; end
               default: begin scl_drv_q <= 1'b0; end
            endcase
         endcase
      end
   end

   assign o_scl      = 1'b0;
   assign o_sda      = 1'b0;
   assign o_scl_oe_n = scl_drv_q;
   assign o_sda_oe_n = sda_drv_q;

   // lost: SDA low while released, or stop not requested
   // Data line judged only at the write sample point, SCL high;
   // slave acknowledge and read bits are never a lost arbitration
   assign al_ev = i_ce && (
      (pen && bop_q == IBC_BOP_WRITE && ph_q == 3'h2 &&
       sda_drv_q && !sda_f) ||
      (stop_det && !stop_req_q && tip_q));

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         al_q <= 1'b0;
      end else if (i_ce) begin
         if (al_ev) al_q <= 1'b1;
         else if (wr_cmd && i_wdata[`IBC_CMD_STA]) al_q <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // Byte sequencer
   //----------------------------------------------------------------
   ibc_state_t st_q;
   logic [7:0] sh_q;
   logic [3:0] bcnt_q;
   logic       issued_q;

   // MSB first; master ack on read, release on write
   assign bit_tx = (st_q == IBC_S_ACK) ? (rdc_q ? ack_q : 1'b1)
                                       : (rdc_q ? 1'b1 : sh_q[7]);

   // Request the bit operation of the current state
   always_comb begin
      bop_d = IBC_BOP_IDLE;
      if (!issued_q) begin
         unique case (st_q)
            IBC_S_START: bop_d = IBC_BOP_START;
            IBC_S_DATA:  bop_d = rdc_q ? IBC_BOP_READ : IBC_BOP_WRITE;
            IBC_S_ACK:   bop_d = rdc_q ? IBC_BOP_WRITE : IBC_BOP_READ;
            IBC_S_STOP:  bop_d = IBC_BOP_STOP;
            default:     bop_d = IBC_BOP_IDLE;
         endcase
      end
   end

   assign done = i_ce && bit_done && (
      (st_q == IBC_S_ACK && !sto_q) || st_q == IBC_S_STOP);

   // start only with read or write; pending run on
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q       <= IBC_S_IDLE;
         sh_q       <= 8'h00;
         bcnt_q     <= 4'h0;
         issued_q   <= 1'b0;
         tip_q      <= 1'b0;
         slave_ack_seen_q    <= 1'b0;
         rxd_q      <= 8'h00;
         stop_req_q <= 1'b0;
      end else if (i_ce) begin
         if (bop_q == IBC_BOP_IDLE && bop_d != IBC_BOP_IDLE) begin
            issued_q <= 1'b1;
         end
         if (al_ev) begin
            st_q       <= IBC_S_IDLE;
            tip_q      <= 1'b0;
            issued_q   <= 1'b0;
            stop_req_q <= 1'b0;
         end else unique case (st_q)
            IBC_S_IDLE: begin
               issued_q <= 1'b0;
               if (rdc_q || wrc_q) begin
                  tip_q  <= 1'b1;
                  sh_q   <= txd_q;
                  bcnt_q <= `IBC_BITS_PER_BYTE;
                  st_q   <= sta_q ? IBC_S_START : IBC_S_DATA;
               end else if (sto_q) begin
                  tip_q      <= 1'b1;
                  stop_req_q <= 1'b1;
                  st_q       <= IBC_S_STOP;
               end
            end
            IBC_S_START: if (bit_done) begin
               issued_q <= 1'b0;
               st_q     <= IBC_S_DATA;
            end
            IBC_S_DATA: if (bit_done) begin
               issued_q <= 1'b0;
               sh_q     <= {sh_q[6:0], rx_bit_q};
               bcnt_q   <= bcnt_q - 4'h1;
               if (bcnt_q == 4'h1) st_q <= IBC_S_ACK;
            end
            IBC_S_ACK: if (bit_done) begin
               issued_q <= 1'b0;
               rxd_q    <= sh_q;
               if (!rdc_q) slave_ack_seen_q <= rx_bit_q;
               if (sto_q) begin
                  stop_req_q <= 1'b1;
                  st_q       <= IBC_S_STOP;
               end else begin
                  tip_q <= 1'b0;
                  st_q  <= IBC_S_IDLE;
               end
            end
            IBC_S_STOP: if (bit_done) begin
               issued_q   <= 1'b0;
               tip_q      <= 1'b0;
               stop_req_q <= 1'b0;
               st_q       <= IBC_S_IDLE;
            end
            default: st_q <= IBC_S_IDLE;
         endcase
      end
   end

endmodule : ibc_core
`default_nettype wire

/* ibc_consts.svh */
// Register map, field positions, reset values and bits per byte
// for the byte-level bus master. Included by the package and the core.
`ifndef IBC_CONSTS_SVH
`define IBC_CONSTS_SVH

// Register offsets
`define IBC_OFS_DIV_LO     3'h0
`define IBC_OFS_DIV_HI     3'h1
`define IBC_OFS_CTRL       3'h2
`define IBC_OFS_DATA       3'h3
`define IBC_OFS_CMD        3'h4

// Control fields
`define IBC_CTRL_EN        7
`define IBC_CTRL_IEN       6

// Command fields
`define IBC_CMD_STA        7
`define IBC_CMD_STO        6
`define IBC_CMD_RD         5
`define IBC_CMD_WR         4
`define IBC_CMD_ACK        3
`define IBC_CMD_INTERRUPT_CLEAR       0

// Status fields
`define IBC_ST_SLAVE_ACK_SEEN       7
`define IBC_ST_BUSY        6
`define IBC_ST_AL          5
`define IBC_ST_TIP         1
`define IBC_ST_IF          0

// Reset values
`define IBC_DIV_RESET      16'hFFFF
`define IBC_CTRL_RESET     8'h00

// Bits per byte
`define IBC_BITS_PER_BYTE  4'h8

`endif

/* ibc_pkg.sv */
// Types shared by the byte-level bus master.
// Assumes ibc_consts.svh is on the include path.
`default_nettype none
`include "ibc_consts.svh"

package ibc_pkg;

   // Bit-level operations
   typedef enum logic [4:0] {
      IBC_BOP_IDLE  = 5'h01,
      IBC_BOP_START = 5'h02,
      IBC_BOP_STOP  = 5'h04,
      IBC_BOP_WRITE = 5'h08,
      IBC_BOP_READ  = 5'h10
   } ibc_bop_t;

   // Byte sequencer states
   typedef enum logic [4:0] {
      IBC_S_IDLE  = 5'h01,
      IBC_S_START = 5'h02,
      IBC_S_DATA  = 5'h04,
      IBC_S_ACK   = 5'h08,
      IBC_S_STOP  = 5'h10
   } ibc_state_t;

endpackage : ibc_pkg
`default_nettype wire

/* ibc_core_checker.sv */
// Checker for the byte-level bus master, bound to its ports.
// Assumes one clock and the reset values of the register map.
`timescale 1ns/1ps
`default_nettype none
module ibc_core_checker (
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_nrst,
   input wire logic       i_ce,
   // Register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // Interrupt and pins
   input wire logic       o_irq,
   input wire logic       i_scl,
   input wire logic       o_scl,
   input wire logic       o_scl_oe_n,
   input wire logic       i_sda,
   input wire logic       o_sda,
   input wire logic       o_sda_oe_n
);
   logic [15:0] div_q;
   logic [7:0]  ctrl_q;
   logic        used_q;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // Shadow of the divider and control registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_q  <= 16'hFFFF;
         ctrl_q <= 8'h00;
         used_q <= 1'b0;
      end else if (i_ce && i_wr) begin
         if (i_addr == 3'h0) div_q[7:0] <= i_wdata;
         if (i_addr == 3'h1) div_q[15:8] <= i_wdata;
         if (i_addr == 3'h2) ctrl_q <= i_wdata & 8'hC0;
         if (i_addr == 3'h2) used_q <= used_q | i_wdata[7];
      end
   end

   chk_div_read: assert property (
      i_ce && i_rd && i_addr < 3'h2 |=> o_rdata ==
      ($past(i_addr[0]) ? div_q[15:8] : div_q[7:0]))
      else $error("divider read back wrong");
   chk_ctrl_read: assert property (
      i_ce && i_rd && i_addr == 3'h2 |=> o_rdata == ctrl_q)
      else $error("control read back wrong");
   chk_unmapped_zero: assert property (
      i_ce && i_rd && i_addr > 3'h4 |=> o_rdata == 8'h00)
      else $error("unmapped offset not zero");
   chk_status_rsvd: assert property (
      i_ce && i_rd && i_addr == 3'h4 |=> o_rdata[4:2] == 3'h0)
      else $error("status reserved bits set");
   chk_irq_gate: assert property (
      !ctrl_q[6] |-> !o_irq)
      else $error("interrupt without enable");
   chk_pins_open: assert property (
      !o_scl && !o_sda)
      else $error("pin driven high");
   chk_quiet_idle: assert property (
      !used_q |-> o_scl_oe_n && o_sda_oe_n)
      else $error("pins pulled while never enabled");
   chk_start_pull: assert property (
      i_ce && i_wr && i_addr == 3'h4 && i_wdata[7] && i_wdata[4] &&
      ctrl_q[7] |-> ##[1:200] !o_sda_oe_n)
      else $error("start did not pull the data line");

   // Main scenarios reached
   cov_write_cmd: cover property (i_wr && i_addr == 3'h4 && i_wdata[4]);
   cov_read_cmd: cover property (i_wr && i_addr == 3'h4 && i_wdata[5]);
   cov_irq: cover property (o_irq);
   cov_stretch: cover property (o_scl_oe_n && !i_scl);
endmodule : ibc_core_checker

bind ibc_core ibc_core_checker u_checker (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_irq(o_irq), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n),
   .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n)
);
`default_nettype wire

/* ibc_slave_model.sv */
// Behavioural bus slave: acks its address, keeps the last written byte,
// returns base plus count when read. The bench resolves the lines.
`timescale 1ns/1ps
`default_nettype none
module ibc_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   // Resolved lines and controls
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic [7:0] i_rd_base,
   input  wire logic       i_stretch,
   // Pulls and observations
   output logic            o_scl_pull,
   output logic            o_sda_pull,
   output logic      [7:0] o_wr_byte,
   output logic            o_ack_seen
);
   logic [7:0] sh = 8'h00;
   logic [7:0] tx = 8'h00;
   logic [7:0] nrd = 8'h00;
   int         cnt = 0;
   logic       slot = 1'b0;
   logic       first = 1'b0;
   logic       sel = 1'b0;
   logic       rdm = 1'b0;
   initial o_scl_pull = 1'b0;
   initial o_sda_pull = 1'b0;

   // Start condition restarts the framing
   always @(negedge i_sda) begin
      if (i_scl === 1'b1) begin
         cnt = 0;
         first = 1'b1;
         slot = 1'b0;
         nrd = 8'h00;
      end
   end

   // Sample data bits and the master's acknowledge
   always @(posedge i_scl) begin
      if (slot) begin
         o_ack_seen = i_sda;
         if (i_sda) sel = 1'b0;
      end else if (cnt < 8) begin
         sh = {sh[6:0], i_sda};
         cnt = cnt + 1;
      end
   end

   // Drive acknowledge or read data while the clock is low
   always @(negedge i_scl) begin
      if (slot) begin
         slot = 1'b0;
         cnt = 0;
         tx = i_rd_base + nrd;
         if (sel && rdm) nrd = nrd + 8'h01;
         o_sda_pull = sel && rdm && !tx[7];
      end else if (cnt == 8) begin
         slot = 1'b1;
         if (first) sel = (sh[7:1] == ADDR);
         if (first) rdm = sh[0];
         if (!first && sel && !rdm) o_wr_byte = sh;
         o_sda_pull = sel && (first || !rdm);
         first = 1'b0;
      end else begin
         o_sda_pull = sel && rdm && !first && !tx[7 - cnt];
      end
      if (i_stretch) begin
         o_scl_pull = 1'b1;
         #400 o_scl_pull = 1'b0;
      end
   end
endmodule : ibc_slave_model
`default_nettype wire

/* ibc_core_bench.sv */
// Self-checking bench: bus master, one slave model, wired-AND lines.
// Assumes ibc_consts.svh on the include path and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "ibc_consts.svh"
module ibc_core_bench;
   localparam logic [6:0] SLV = 7'h2A;
   logic       i_clk, i_nrst, i_ce, i_wr, i_rd;
   logic [2:0] i_addr;
   logic [7:0] i_wdata, o_rdata, wr_byte, rd_base;
   logic       o_irq, o_scl, o_scl_oe_n, o_sda, o_sda_oe_n;
   logic       s_scl, s_sda, tb_sda, stretch, mack;
   wire        scl, sda;
   int         miscompares = 0;
   int         comparisons = 0;

   // Open-drain lines with pull-ups
   assign scl = (o_scl_oe_n | o_scl) & ~s_scl;
   assign sda = (o_sda_oe_n | o_sda) & ~s_sda & ~tb_sda;

   ibc_core dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_irq(o_irq), .i_scl(scl), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n),
      .i_sda(sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n)
   );
   ibc_slave_model #(.ADDR(SLV)) u_slave (
      .i_scl(scl), .i_sda(sda), .i_rd_base(rd_base), .i_stretch(stretch),
      .o_scl_pull(s_scl), .o_sda_pull(s_sda), .o_wr_byte(wr_byte),
      .o_ack_seen(mack)
   );

   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   // Poll status until one bit reaches a level, bounded
   task automatic poll(input int b, input logic v, output logic [7:0] st);
      int n;
      st = 8'h00;
      st[b] = ~v;
      for (n = 0; n < 4000 && st[b] !== v; n++) rd(`IBC_OFS_CMD, st);
      if (st[b] !== v) begin
         miscompares++;
         stop_test();
      end
   endtask : poll

   // Issue a byte command and wait for it to finish
   task automatic xfer(input logic [7:0] c, output logic [7:0] st);
      wr(`IBC_OFS_CMD, c);
      rd(`IBC_OFS_CMD, st);
      chk("in progress", 8'h02, st & 8'h02);
      poll(1, 1'b0, st);
   endtask : xfer

   function automatic logic [7:0] rx_exp(input int k);
      return rd_base + 8'(k);
   endfunction : rx_exp

   // Clock
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge i_clk);
      miscompares++;
      stop_test();
   end

   // Main sequence
   initial begin : main
      logic [7:0] d, v, st;
      int         a;
      i_nrst = 1'b0;
      i_ce = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 3'h0;
      i_wdata = 8'h00;
      tb_sda = 1'b0;
      stretch = 1'b0;
      rd_base = 8'h00;
      void'($urandom(68072));
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      // Reset values, unmapped offsets included
      for (a = 0; a < 8; a++) begin
         rd(a[2:0], d);
         chk("reset value", (a < 2) ? 8'hFF : 8'h00, d);
      end
      // Divider changed only while disabled
      for (a = 0; a < 4; a++) begin
         v = 8'($urandom);
         wr(a[0] ? `IBC_OFS_DIV_HI : `IBC_OFS_DIV_LO, v);
         rd(a[0] ? `IBC_OFS_DIV_HI : `IBC_OFS_DIV_LO, d);
         chk("divider", v, d);
      end
      wr(`IBC_OFS_DIV_LO, 8'h04);
      wr(`IBC_OFS_DIV_HI, 8'h00);
      wr(`IBC_OFS_CTRL, 8'h3F);
      rd(`IBC_OFS_CTRL, d);
      chk("ctrl reserved", 8'h00, d);
      wr(`IBC_OFS_CMD, 8'h90);
      repeat (200) @(posedge i_clk);
      rd(`IBC_OFS_CMD, st);
      chk("disabled", 8'h00, st);
      // Address for writing, interrupt gating and clearing
      wr(`IBC_OFS_CTRL, 8'h80);
      wr(`IBC_OFS_DATA, {SLV, 1'b0});
      xfer(8'h90, st);
      chk("address ack", 8'h41, st);
      chk("irq gated", 8'h00, {7'h00, o_irq});
      wr(`IBC_OFS_CTRL, 8'hC0);
      @(negedge i_clk);
      chk("irq raised", 8'h01, {7'h00, o_irq});
      wr(`IBC_OFS_CMD, 8'h01);
      rd(`IBC_OFS_CMD, st);
      chk("flag cleared", 8'h40, st);
      // Data bytes, corner values first
      for (a = 0; a < 5; a++) begin
         v = (a == 0) ? 8'hFF : (a == 1) ? 8'h00 : 8'($urandom);
         wr(`IBC_OFS_DATA, v);
         // Clock enable low: this write must leave no trace
         i_ce <= 1'b0;
         wr(`IBC_OFS_DATA, ~v);
         i_ce <= 1'b1;
         xfer(8'h11, st);
         chk("slave byte", v, wr_byte);
         chk("write status", 8'h41, st);
      end
      // Repeated start into reads, slave stretching the clock
      stretch = 1'b1;
      rd_base = 8'($urandom);
      wr(`IBC_OFS_DATA, {SLV, 1'b1});
      xfer(8'h91, st);
      chk("read address", 8'h41, st);
      for (a = 0; a < 3; a++) begin
         xfer((a == 2) ? 8'h69 : 8'h21, st);
         rd(`IBC_OFS_DATA, d);
         chk("read byte", rx_exp(a), d);
         chk("master ack", (a == 2) ? 8'h01 : 8'h00, {7'h00, mack});
      end
      poll(6, 1'b0, st);
      chk("bus free", 8'h01, st & 8'h43);
      // Unanswered address, then a plain stop
      stretch = 1'b0;
      wr(`IBC_OFS_DATA, {SLV ^ 7'h01, 1'b0});
      xfer(8'h91, st);
      chk("no ack", 8'hC1, st);
      wr(`IBC_OFS_CMD, 8'h41);
      // Disable beside the pending stop; the stop must still finish
      wr(`IBC_OFS_CTRL, 8'h40);
      poll(6, 1'b0, st);
      chk("stopped", 8'h00, st & 8'h40);
      wr(`IBC_OFS_CTRL, 8'hC0);
      // Another party holds the data line low
      wr(`IBC_OFS_DATA, 8'hFF);
      wr(`IBC_OFS_CMD, 8'h91);
      for (a = 0; a < 500 && scl; a++) @(posedge i_clk);
      tb_sda <= 1'b1;
      poll(0, 1'b1, st);
      chk("arbitration", 8'h21, st & 8'h23);
      tb_sda <= 1'b0;
      stop_test();
   end
endmodule : ibc_core_bench
`default_nettype wire
